// [shared/lrc_defs.svh]
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH
// Register indices; byte address is four times the index.
`define LRC_IDX_RATIO 10'h02c
`define LRC_IDX_CTRL 10'h030
`define LRC_IDX_PRIO 10'h031
`define LRC_IDX_VARBW 10'h0bb
`define LRC_IDX_MODE 10'h0c0
`define LRC_IDX_STATUS 10'h0c1
`define LRC_IDX_FREQ 10'h0c2
// Reset values.
`define LRC_RST_RATIO 32'h00010001
`define LRC_RST_CTRL 8'h0c
`define LRC_RST_PRIO 8'h32
`define LRC_RST_VARBW 8'h00
`define LRC_RST_MODE 2'h1
// Writable bits; reserved bits keep their defaults.
`define LRC_CTRL_WMASK 8'hfc
`define LRC_PRIO_WMASK 8'h77
// Field positions.
`define LRC_DEN_LSB 0
`define LRC_NUM_LSB 16
`define LRC_SLOPE_LSB 2
`define LRC_REALIGN_BIT 4
`define LRC_BW_LSB 5
`define LRC_PRIO2_LSB 0
`define LRC_PRIO3_LSB 4
// Slope limits in ns per second.
`define LRC_SLOPE_0_NS 32'h0000ee48
`define LRC_SLOPE_1_NS 32'h00001d4c
`define LRC_SLOPE_2_NS 32'h00000375
`define LRC_BW_BASE_HZ 16'h000e
`define LRC_BW_VAR 3'h7
`define LRC_PRIO_OFF 3'h7
`define LRC_DIV_STEPS 6'h30
`define LRC_RESP_OKAY 2'h0
`define LRC_RESP_SLVERR 2'h2
`endif

// [shared/lrc_pkg.sv]
package lrc_pkg;
  // Phases of the expected-frequency divider.
  typedef enum logic [1:0] {
    LRC_DIV_IDLE,
    LRC_DIV_RUN,
    LRC_DIV_DONE
  } lrc_div_state_t;
endpackage

// [rtl/lrc_loop_ref_config_regs.sv]
// Function
// - Ratio word holds denominator in bits 15:0, numerator in 31:16.
// - Expected frequency is base times multiple times numerator over denominator.
// - Slope field 00/01/10/11 gives 61, 7.5, 0.885 us/s or unlimited.
// - Realign bit set aligns loop output phase with the selected input.
// - Bandwidth codes 000 to 110 give 14 Hz doubling up to 896 Hz.
// - Bandwidth code 111 takes bandwidth from the variable-bandwidth register.
// - Priority fields rank inputs only in automatic switching mode.
// - Code 000 ranks highest, 001 second, 010 third.
// - Switch back to a lower-numbered input as soon as it recovers.
// - Do not switch between equal-priority inputs merely on recovery.
// - Revertive across levels and non-revertive within one level together.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_defs.svh"
module lrc_loop_ref_config_regs
  import lrc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] base_frequency,
  input wire logic [15:0] base_multiple,
  input wire logic input_two_fail,
  input wire logic input_three_fail,
  output logic [15:0] input_three_fec_numerator,
  output logic [15:0] input_three_fec_denominator,
  output logic [31:0] expected_freq_hz,
  output logic expected_freq_valid,
  output logic [31:0] phase_slope_limit_ns,
  output logic phase_slope_unlimited,
  output logic phase_realign,
  output logic [15:0] loop_bandwidth_hz,
  output logic loop_bandwidth_variable,
  output logic [7:0] variable_bandwidth,
  output logic selected_input_three,
  output logic selection_valid
);

  // ************************************************************
  // Register bus slave
  // ************************************************************
  logic [31:0] ratio_reg, wdata_reg, wmask, ratio_next, status_word, rdata_next;
  logic [7:0] ctrl_reg, prio_reg, varbw_reg;
  logic [1:0] mode_reg, rresp_next;
  logic aw_held_reg, w_held_reg, do_write, wr_hit;
  logic [9:0] aw_idx_reg, ar_idx;
  logic [3:0] wstrb_reg;
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid & ce;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid & ce;
  assign s_axi_arready = ~s_axi_rvalid & ce;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid & ce;

  // Address and data are caught separately, so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 10'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[11:2];
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end
  // Byte lanes become a bit mask; a whole word lands in one beat.
  always_comb begin
    wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    ratio_next = (ratio_reg & ~wmask) | (wdata_reg & wmask);
    wr_hit = 1'b0;
    if (aw_idx_reg == `LRC_IDX_RATIO) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `LRC_IDX_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `LRC_IDX_PRIO) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `LRC_IDX_VARBW) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `LRC_IDX_MODE) begin
      wr_hit = 1'b1;
    end
  end
  // Write response follows both halves of the request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LRC_RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Configuration registers; reserved bits are masked and keep their defaults.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ratio_reg <= `LRC_RST_RATIO;
      ctrl_reg <= `LRC_RST_CTRL;
      prio_reg <= `LRC_RST_PRIO;
      varbw_reg <= `LRC_RST_VARBW;
      mode_reg <= `LRC_RST_MODE;
    end else if (do_write && (wstrb_reg[0] || aw_idx_reg == `LRC_IDX_RATIO)) begin
      if (aw_idx_reg == `LRC_IDX_RATIO) begin
        ratio_reg <= ratio_next;
      end else if (aw_idx_reg == `LRC_IDX_CTRL) begin
        ctrl_reg <= (wdata_reg[7:0] & `LRC_CTRL_WMASK) | (`LRC_RST_CTRL & ~`LRC_CTRL_WMASK);
      end else if (aw_idx_reg == `LRC_IDX_PRIO) begin
        prio_reg <= (wdata_reg[7:0] & `LRC_PRIO_WMASK) | (`LRC_RST_PRIO & ~`LRC_PRIO_WMASK);
      end else if (aw_idx_reg == `LRC_IDX_VARBW) begin
        varbw_reg <= wdata_reg[7:0];
      end else if (aw_idx_reg == `LRC_IDX_MODE) begin
        mode_reg <= wdata_reg[1:0];
      end
    end
  end
  // Read decode; unmapped addresses read zero with an error response.
  always_comb begin
    ar_idx = s_axi_araddr[11:2];
    rdata_next = 32'h00000000;
    rresp_next = `LRC_RESP_OKAY;
    if (ar_idx == `LRC_IDX_RATIO) begin
      rdata_next = ratio_reg;
    end else if (ar_idx == `LRC_IDX_CTRL) begin
      rdata_next = {24'h000000, ctrl_reg};
    end else if (ar_idx == `LRC_IDX_PRIO) begin
      rdata_next = {24'h000000, prio_reg};
    end else if (ar_idx == `LRC_IDX_VARBW) begin
      rdata_next = {24'h000000, varbw_reg};
    end else if (ar_idx == `LRC_IDX_MODE) begin
      rdata_next = {30'h00000000, mode_reg};
    end else if (ar_idx == `LRC_IDX_STATUS) begin
      rdata_next = status_word;
    end else if (ar_idx == `LRC_IDX_FREQ) begin
      rdata_next = expected_freq_hz;
    end else begin
      rresp_next = `LRC_RESP_SLVERR;
    end
  end
  // Read data stands until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LRC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rresp_next;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Loop control decode
  // ************************************************************
  logic [1:0] slope_code;
  logic [2:0] bw_code;
  assign slope_code = ctrl_reg[`LRC_SLOPE_LSB +: 2];
  assign bw_code = ctrl_reg[`LRC_BW_LSB +: 3];
  assign input_three_fec_denominator = ratio_reg[`LRC_DEN_LSB +: 16];
  assign input_three_fec_numerator = ratio_reg[`LRC_NUM_LSB +: 16];
  assign variable_bandwidth = varbw_reg;
  // Loop settings are registered so the loop sees clean levels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_slope_limit_ns <= 32'h00000000;
      phase_slope_unlimited <= 1'b1;
      phase_realign <= 1'b0;
      loop_bandwidth_hz <= `LRC_BW_BASE_HZ;
      loop_bandwidth_variable <= 1'b0;
    end else if (ce) begin
      phase_slope_unlimited <= (slope_code == 2'h3);
      case (slope_code)
        2'h0: phase_slope_limit_ns <= `LRC_SLOPE_0_NS;
        2'h1: phase_slope_limit_ns <= `LRC_SLOPE_1_NS;
        2'h2: phase_slope_limit_ns <= `LRC_SLOPE_2_NS;
        default: phase_slope_limit_ns <= 32'h00000000;
      endcase
      phase_realign <= ctrl_reg[`LRC_REALIGN_BIT];
      loop_bandwidth_variable <= (bw_code == `LRC_BW_VAR);
      if (bw_code == `LRC_BW_VAR) begin
        loop_bandwidth_hz <= {8'h00, varbw_reg};
      end else begin
        loop_bandwidth_hz <= `LRC_BW_BASE_HZ << bw_code;
      end
    end
  end

  // ************************************************************
  // Reference selection
  // ************************************************************
  logic [2:0] prio_two, prio_three;
  logic ok_two, ok_three, sel_next, valid_next, cur_ok;
  assign prio_two = prio_reg[`LRC_PRIO2_LSB +: 3];
  assign prio_three = prio_reg[`LRC_PRIO3_LSB +: 3];
  assign ok_two = ~input_two_fail & (prio_two != `LRC_PRIO_OFF);
  assign ok_three = ~input_three_fail & (prio_three != `LRC_PRIO_OFF);
  assign cur_ok = selection_valid & (selected_input_three ? ok_three : ok_two);
  // A lower number outranks a higher one; equal numbers keep the current input.
  always_comb begin
    sel_next = selected_input_three;
    valid_next = 1'b1;
    if (!mode_reg[0]) begin
      sel_next = mode_reg[1];
    end else if (cur_ok) begin
      if (selected_input_three && ok_two && prio_two < prio_three) begin
        sel_next = 1'b0;
      end else if (!selected_input_three && ok_three && prio_three < prio_two) begin
        sel_next = 1'b1;
      end
    end else if (ok_two && ok_three) begin
      sel_next = (prio_three < prio_two);
    end else if (ok_two || ok_three) begin
      sel_next = ok_three;
    end else begin
      valid_next = 1'b0;
    end
  end

  // In automatic mode, without a usable input the loop is left in holdover.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selected_input_three <= 1'b0;
      selection_valid <= 1'b0;
    end else if (ce) begin
      selected_input_three <= sel_next;
      selection_valid <= valid_next;
    end
  end

  // ************************************************************
  // Expected frequency divider
  // ************************************************************
  lrc_div_state_t div_state;
  logic [47:0] prod_reg, quot_reg, prod_now;
  logic [15:0] den_reg;
  logic [16:0] rem_reg, rem_shift;
  logic [5:0] step_reg;
  logic div_zero_reg;
  assign prod_now = (48'(base_frequency) * 48'(base_multiple)) * 48'(input_three_fec_numerator);
  assign rem_shift = {rem_reg[15:0], quot_reg[47]}; // The quotient register shifts the dividend out of its top.
  assign status_word = {26'h0000000, div_zero_reg, expected_freq_valid, (div_state != LRC_DIV_IDLE),
    ~mode_reg[0], selection_valid, selected_input_three};
  // Restoring division, one quotient bit per cycle; an operand change starts a new division once the running one ends.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_state <= LRC_DIV_IDLE;
      prod_reg <= 48'h000000000000;
      quot_reg <= 48'h000000000000;
      den_reg <= 16'h0000;
      rem_reg <= 17'h00000;
      step_reg <= 6'h00;
      expected_freq_hz <= 32'h00000000;
      expected_freq_valid <= 1'b0;
      div_zero_reg <= 1'b0;
    end else if (ce) begin
      case (div_state)
        LRC_DIV_IDLE: begin
          if (!expected_freq_valid || prod_now != prod_reg || input_three_fec_denominator != den_reg) begin
            prod_reg <= prod_now;
            den_reg <= input_three_fec_denominator;
            quot_reg <= prod_now;
            rem_reg <= 17'h00000;
            step_reg <= `LRC_DIV_STEPS;
            expected_freq_valid <= 1'b0;
            div_state <= LRC_DIV_RUN;
          end
        end
        LRC_DIV_RUN: begin
          quot_reg <= {quot_reg[46:0], (rem_shift >= {1'b0, den_reg})};
          if (rem_shift >= {1'b0, den_reg}) begin
            rem_reg <= rem_shift - {1'b0, den_reg};
          end else begin
            rem_reg <= rem_shift;
          end
          step_reg <= step_reg - 6'h01;
          if (step_reg == 6'h01) begin
            div_state <= LRC_DIV_DONE;
          end
        end
        default: begin
          div_zero_reg <= (den_reg == 16'h0000);
          expected_freq_hz <= (den_reg == 16'h0000) ? 32'h00000000 : quot_reg[31:0];
          expected_freq_valid <= 1'b1;
          div_state <= LRC_DIV_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_ratio_halves: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_idx_reg == `LRC_IDX_RATIO && wstrb_reg == 4'hf |=>
    input_three_fec_numerator == $past(wdata_reg[31:16]) && input_three_fec_denominator == $past(wdata_reg[15:0]))
    else $error("ratio halves not stored");
  a_freq_quotient: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(expected_freq_valid) && den_reg != 16'h0000 && prod_reg[47:32] == 16'h0000 |->
    64'(expected_freq_hz) * 64'(den_reg) <= 64'(prod_reg) &&
    64'(prod_reg) < (64'(expected_freq_hz) + 64'h1) * 64'(den_reg))
    else $error("expected frequency wrong");
  a_slope_code: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && slope_code == 2'h1 |=> phase_slope_limit_ns == `LRC_SLOPE_1_NS && !phase_slope_unlimited)
    else $error("slope limit wrong");
  a_realign_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> phase_realign == $past(ctrl_reg[`LRC_REALIGN_BIT]))
    else $error("realign level wrong");
  a_bw_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bw_code == 3'h6 |=> loop_bandwidth_hz == 16'h0380 && !loop_bandwidth_variable)
    else $error("fixed bandwidth wrong");
  a_bw_variable: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bw_code == `LRC_BW_VAR |=> loop_bandwidth_variable && loop_bandwidth_hz[7:0] == $past(varbw_reg))
    else $error("variable bandwidth wrong");
  a_manual_select: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !mode_reg[0] |=> selected_input_three == $past(mode_reg[1]) && selection_valid)
    else $error("manual selection ignored");
  a_revert_higher: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mode_reg[0] && selection_valid && selected_input_three && ok_three && ok_two &&
    prio_two < prio_three |=> !selected_input_three)
    else $error("no revert to better input");
  a_hold_equal: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mode_reg[0] && cur_ok && prio_two == prio_three |=> $stable(selected_input_three) && selection_valid)
    else $error("switched within a level");
  a_disabled_input: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mode_reg[0] && prio_two == `LRC_PRIO_OFF && prio_three == `LRC_PRIO_OFF |=> !selection_valid)
    else $error("disabled input selected");
endmodule // lrc_loop_ref_config_regs
`default_nettype wire

// [test/tb_lrc_loop_ref_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lrc_defs.svh"
module tb_lrc_loop_ref_config_regs;
  // ************************************************************
  // Signals and stimulus table
  // ************************************************************
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] rd;
    logic [31:0] slope;
    logic unl;
    logic re;
    logic [15:0] bw;
    logic bvar;
  } lrc_tb_row_t;

  localparam int TIMEOUT = 20000;
  logic aclk = 1'b0;
  logic aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, input_two_fail, input_three_fail;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, expected_freq_hz, phase_slope_limit_ns;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] base_frequency, base_multiple, input_three_fec_numerator, input_three_fec_denominator;
  logic [15:0] loop_bandwidth_hz;
  logic [7:0] variable_bandwidth;
  logic expected_freq_valid, phase_slope_unlimited, phase_realign, loop_bandwidth_variable;
  logic selected_input_three, selection_valid;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  // Control byte rows: value written, value read back, decoded outputs. The last row uses the variable bandwidth.
  lrc_tb_row_t rows [8] = '{
    '{8'h03, 8'h00, `LRC_SLOPE_0_NS, 1'b0, 1'b0, 16'h000e, 1'b0},
    '{8'h34, 8'h34, `LRC_SLOPE_1_NS, 1'b0, 1'b1, 16'h001c, 1'b0},
    '{8'h48, 8'h48, `LRC_SLOPE_2_NS, 1'b0, 1'b0, 16'h0038, 1'b0},
    '{8'h7c, 8'h7c, 32'h00000000, 1'b1, 1'b1, 16'h0070, 1'b0},
    '{8'h80, 8'h80, `LRC_SLOPE_0_NS, 1'b0, 1'b0, 16'h00e0, 1'b0},
    '{8'ha4, 8'ha4, `LRC_SLOPE_1_NS, 1'b0, 1'b0, 16'h01c0, 1'b0},
    '{8'hc8, 8'hc8, `LRC_SLOPE_2_NS, 1'b0, 1'b0, 16'h0380, 1'b0},
    '{8'hec, 8'hec, 32'h00000000, 1'b1, 1'b0, 16'h005a, 1'b1}
  };

  lrc_loop_ref_config_regs u_lrc_loop_ref_config_regs (.*);

  // Free-running clock at 100 MHz.
  always #5 aclk = ~aclk;

  // Cycle ceiling; the whole run needs a few hundred cycles, so the ceiling lies far above a normal run.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write one word; address and data halves are released independently as each is taken.
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    check("rdata", s_axi_rdata, ed);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // The divider takes about fifty cycles. A division still running on older operands shows valid first and
  // then drops it to restart, so the wait is done twice; a current result stays valid through the second pass.
  task automatic wait_freq();
    repeat (2) begin
      tick(3);
      for (int k = 0; k < 200 && expected_freq_valid !== 1'b1; k++) @(posedge aclk);
    end
    check("freq_valid", expected_freq_valid, 1'b1);
  endtask

  task automatic sel(input logic three, input logic ok);
    tick(2);
    check("sel_three", selected_input_three, three);
    check("sel_valid", selection_valid, ok);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    base_frequency = 16'h03e8;
    base_multiple = 16'h0008;
    input_two_fail = 1'b0;
    input_three_fail = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Defaults straight after reset.
    check("num_rst", input_three_fec_numerator, 16'h0001);
    check("den_rst", input_three_fec_denominator, 16'h0001);
    check("unl_rst", phase_slope_unlimited, 1'b1);
    check("bw_rst", loop_bandwidth_hz, 16'h000e);
    rd(`LRC_IDX_RATIO, `LRC_RST_RATIO, `LRC_RESP_OKAY);
    rd(`LRC_IDX_CTRL, {24'h0, `LRC_RST_CTRL}, `LRC_RESP_OKAY);
    rd(`LRC_IDX_PRIO, {24'h0, `LRC_RST_PRIO}, `LRC_RESP_OKAY);
    rd(`LRC_IDX_MODE, 32'h00000001, `LRC_RESP_OKAY);
    // Every slope, bandwidth and realign code through the table.
    wr(`LRC_IDX_VARBW, 32'h0000005a, 4'h1, `LRC_RESP_OKAY);
    foreach (rows[i]) begin
      wr(`LRC_IDX_CTRL, {24'h0, rows[i].wr}, 4'h1, `LRC_RESP_OKAY);
      rd(`LRC_IDX_CTRL, {24'h0, rows[i].rd}, `LRC_RESP_OKAY);
      check("slope_ns", phase_slope_limit_ns, rows[i].slope);
      check("slope_unl", phase_slope_unlimited, rows[i].unl);
      check("realign", phase_realign, rows[i].re);
      check("bw_hz", loop_bandwidth_hz, rows[i].bw);
      check("bw_var", loop_bandwidth_variable, rows[i].bvar);
      check("varbw", variable_bandwidth, 8'h5a);
    end
    // Ratio fields and the expected frequency: 1000 * 8 * 255 / 237, truncated.
    wr(`LRC_IDX_RATIO, 32'h00ff00ed, 4'hf, `LRC_RESP_OKAY);
    wait_freq();
    check("num", input_three_fec_numerator, 16'h00ff);
    check("den", input_three_fec_denominator, 16'h00ed);
    check("freq", expected_freq_hz, 32'h0000219f);
    rd(`LRC_IDX_FREQ, 32'h0000219f, `LRC_RESP_OKAY);
    // Upper lanes only: the denominator must survive.
    wr(`LRC_IDX_RATIO, 32'h41be0000, 4'hc, `LRC_RESP_OKAY);
    rd(`LRC_IDX_RATIO, 32'h41be00ed, `LRC_RESP_OKAY);
    // A zero denominator must not hang the divider.
    wr(`LRC_IDX_RATIO, 32'h00010000, 4'hf, `LRC_RESP_OKAY);
    wait_freq();
    check("freq_den0", expected_freq_hz, 32'h00000000);
    rd(`LRC_IDX_STATUS, 32'h00000032, `LRC_RESP_OKAY);
    wr(`LRC_IDX_RATIO, 32'h00010001, 4'hf, `LRC_RESP_OKAY);
    wait_freq();
    check("freq_one", expected_freq_hz, 32'h00001f40);
    // Unmapped place and reserved priority bits.
    rd(10'h001, 32'h00000000, `LRC_RESP_SLVERR);
    wr(10'h001, 32'hffffffff, 4'hf, `LRC_RESP_SLVERR);
    wr(`LRC_IDX_PRIO, 32'h000000ff, 4'h1, `LRC_RESP_OKAY);
    rd(`LRC_IDX_PRIO, 32'h00000077, `LRC_RESP_OKAY);
    sel(1'b0, 1'b0);
    // Switching below runs with the realign bit cleared, as hitless switching asks.
    check("realign_off", phase_realign, 1'b0);
    // Codes 0 to 6 on both fields; equal codes at c = 3 must leave the choice alone.
    for (int c = 0; c < 7; c++) begin
      wr(`LRC_IDX_PRIO, {25'h0, 3'(c), 1'b0, 3'(6 - c)}, 4'h1, `LRC_RESP_OKAY);
      sel(c <= 3, 1'b1);
    end
    // Different levels: return to the better input once it recovers.
    wr(`LRC_IDX_PRIO, 32'h00000032, 4'h1, `LRC_RESP_OKAY);
    input_two_fail <= 1'b1;
    sel(1'b1, 1'b1);
    input_two_fail <= 1'b0;
    sel(1'b0, 1'b1);
    // Same level: recovery alone never causes a switch.
    wr(`LRC_IDX_PRIO, 32'h00000011, 4'h1, `LRC_RESP_OKAY);
    input_two_fail <= 1'b1;
    sel(1'b1, 1'b1);
    input_two_fail <= 1'b0;
    sel(1'b1, 1'b1);
    input_three_fail <= 1'b1;
    sel(1'b0, 1'b1);
    input_three_fail <= 1'b0;
    sel(1'b0, 1'b1);
    // Disabled input is never chosen; with the other failed the loop has nothing.
    wr(`LRC_IDX_PRIO, 32'h00000007, 4'h1, `LRC_RESP_OKAY);
    sel(1'b1, 1'b1);
    input_three_fail <= 1'b1;
    sel(1'b1, 1'b0);
    // Manual mode ignores priorities and failures.
    wr(`LRC_IDX_MODE, 32'h00000000, 4'h1, `LRC_RESP_OKAY);
    sel(1'b0, 1'b1);
    wr(`LRC_IDX_MODE, 32'h00000002, 4'h1, `LRC_RESP_OKAY);
    sel(1'b1, 1'b1);
    wr(`LRC_IDX_MODE, 32'h00000001, 4'h1, `LRC_RESP_OKAY);
    sel(1'b1, 1'b0);
    // Clock enable low closes the bus; a reset in mid-run, with enable still low, restores the defaults.
    ce <= 1'b0;
    tick(2);
    check("ce_ready", {29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h00000000);
    aresetn <= 1'b0;
    tick(2);
    ce <= 1'b1;
    aresetn <= 1'b1;
    tick(1);
    rd(`LRC_IDX_CTRL, {24'h0, `LRC_RST_CTRL}, `LRC_RESP_OKAY);
    tally_and_finish();
  end
endmodule // tb_lrc_loop_ref_config_regs
`default_nettype wire
